// ===== rtl/fcpl_regs.vh
/*
 * Register map constants for the front-end configuration and host port lock bank.
 * Assumes a 16-bit register address and 8-bit data from the host serial port engine.
 */
`ifndef FCPL_REGS_VH
`define FCPL_REGS_VH

// ****************************************
// Offsets
// ****************************************
`define FCPL_FRONTEND_CONFIG_ADDR 16'he708
`define FCPL_HOST_PORT_LOCK_ADDR 16'hea00

// ****************************************
// Field positions
// ****************************************
`define FCPL_SEL_A_BIT 0
`define FCPL_SEL_B_BIT 1
`define FCPL_SEL_C_BIT 2
`define FCPL_SEL_N_BIT 3
`define FCPL_CLK_OFF_BIT 6
`define FCPL_SOFT_RST_BIT 7
`define FCPL_LOCK_BIT 0

// ****************************************
// Reset values and timing
// ****************************************
`define FCPL_FRONTEND_CONFIG_RST 8'h0f
`define FCPL_HOST_PORT_LOCK_RST 8'h00
`define FCPL_STROBE_TOGGLES 2'h3
`define FCPL_CLK_DIV_HALF 4'h4

`endif

// ===== rtl/fcpl_strobe_count.v
/*
 * Counts toggles of the select strobe pin and flags the switch to SPI.
 * Assumes the pin input arrives asynchronous; it is synchronised here.
 */
`timescale 1ns/100ps
`include "fcpl_regs.vh"

module fcpl_strobe_count
(
	input wire mclk,
	input wire arst_n,
	input wire strobe_pin,
	input wire locked,
	output reg spi_sel
);

reg sync_a;
reg sync_b;
reg last;
reg [1:0] toggles;

// ****************************************
// Synchroniser and toggle counter
// ****************************************
// Only the second stage feeds the edge detector
always @(posedge mclk or negedge arst_n)
begin
	if (!arst_n)
	begin
		sync_a <= 1'b1;
		sync_b <= 1'b1;
		last <= 1'b1;
		toggles <= 2'h0;
		spi_sel <= 1'b0;
	end
	else
	begin
		sync_a <= strobe_pin;
		sync_b <= sync_a;
		last <= sync_b;
		// Once locked the pin is ignored entirely
		if (!locked && !spi_sel && (sync_b != last))
		begin
			if (toggles == `FCPL_STROBE_TOGGLES - 2'h1)
				spi_sel <= 1'b1;
			toggles <= toggles + 2'h1;
		end
	end
end

endmodule

// ===== rtl/fcpl_top.v
/*
 * Front-end configuration register and host port lock register bank.
 * Assumes the host serial engine delivers one-cycle write and read strobes
 * with address and data on mclk; reads return data one cycle later.
 */
`timescale 1ns/100ps
`include "fcpl_regs.vh"

module fcpl_top
#(
	parameter CLK_HALF = `FCPL_CLK_DIV_HALF
)
(
	input wire mclk,
	input wire arst_n,
	input wire [15:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	input wire select_strobe_pin,
	output wire spi_active,
	output wire port_locked,
	output reg [3:0] second_input_sel,
	output reg frontend_clock_output,
	output reg frontend_soft_reset
);

reg [7:0] frontend_config;
reg lock_bit;
reg [3:0] div_cnt;
wire spi_sel;
wire wr_cfg;
wire wr_lock;

// Reset images of both registers, indexed per bit below
localparam [7:0] CFG_RST = `FCPL_FRONTEND_CONFIG_RST;
localparam [7:0] LOCK_RST = `FCPL_HOST_PORT_LOCK_RST;

// ****************************************
// Address decode
// ****************************************
// Full 16-bit match; a partial decode would alias other banks onto these
// registers, and a stray write could then stop the front-end clocks
function addr_hit;
	input [15:0] addr;
	input [15:0] base;
	begin
		addr_hit = (addr == base);
	end
endfunction

// Write strobes qualified by address; both are one cycle wide
assign wr_cfg = reg_wr && addr_hit(reg_addr, `FCPL_FRONTEND_CONFIG_ADDR);
assign wr_lock = reg_wr && addr_hit(reg_addr, `FCPL_HOST_PORT_LOCK_ADDR);

// Status levels straight from flops, no extra delay
assign spi_active = spi_sel;
assign port_locked = lock_bit;

// ****************************************
// Strobe toggle detection
// ****************************************
fcpl_strobe_count u_strobe
(
	.mclk(mclk),
	.arst_n(arst_n),
	.strobe_pin(select_strobe_pin),
	.locked(lock_bit),
	.spi_sel(spi_sel)
);

// ****************************************
// Register writes
// ****************************************
// Reserved bits are never stored
always @(posedge mclk or negedge arst_n)
begin
	if (!arst_n)
	begin
		frontend_config <= `FCPL_FRONTEND_CONFIG_RST;
		frontend_soft_reset <= 1'b0;
	end
	else
	begin
		frontend_soft_reset <= 1'b0;
		if (wr_cfg)
		begin
			frontend_config[3:0] <= reg_wdata[3:0];
			frontend_config[5:4] <= 2'h0;
			frontend_config[`FCPL_CLK_OFF_BIT] <= reg_wdata[`FCPL_CLK_OFF_BIT];
			frontend_soft_reset <= reg_wdata[`FCPL_SOFT_RST_BIT];
		end
		// Soft reset bit never stored, so it reads 0
		frontend_config[`FCPL_SOFT_RST_BIT] <= 1'b0;
	end
end

// ****************************************
// Host port lock
// ****************************************
// Sticky until hardware reset; software has no way back
// Under SPI the written value is ignored, so even a stray zero locks
always @(posedge mclk or negedge arst_n)
begin
	if (!arst_n)
		lock_bit <= LOCK_RST[`FCPL_LOCK_BIT];
	else if (wr_lock && !lock_bit)
	begin
		if (spi_sel)
			lock_bit <= 1'b1;
		else
			lock_bit <= reg_wdata[`FCPL_LOCK_BIT];
	end
end

// ****************************************
// Outputs to front ends
// ****************************************
// Clock divider; when stopped the pin is held high
always @(posedge mclk or negedge arst_n)
begin
	if (!arst_n)
	begin
		div_cnt <= 4'h0;
		frontend_clock_output <= 1'b1;
	end
	else
	begin
		if (frontend_config[`FCPL_CLK_OFF_BIT])
		begin
			div_cnt <= 4'h0;
			frontend_clock_output <= 1'b1;
		end
		else if (div_cnt == CLK_HALF[3:0] - 4'h1)
		begin
			div_cnt <= 4'h0;
			frontend_clock_output <= ~frontend_clock_output;
		end
		else
			div_cnt <= div_cnt + 4'h1;
	end
end

// ****************************************
// Per-phase second channel select
// ****************************************
// One flop per front end: phase A, B, C, then neutral
// A front end with a fixed temperature channel still needs its bit cleared
genvar gi;
generate
	for (gi = 0; gi < 4; gi = gi + 1)
	begin : g_sel
		always @(posedge mclk or negedge arst_n)
		begin
			if (!arst_n)
				second_input_sel[gi] <= CFG_RST[gi];
			else
				second_input_sel[gi] <= frontend_config[gi];
		end
	end
endgenerate

// ****************************************
// Register reads
// ****************************************
// Unmapped addresses read zero; data holds until the next read strobe
always @(posedge mclk or negedge arst_n)
begin
	if (!arst_n)
		reg_rdata <= 8'h00;
	else if (reg_rd)
	begin
		if (addr_hit(reg_addr, `FCPL_FRONTEND_CONFIG_ADDR))
			reg_rdata <= frontend_config;
		else if (addr_hit(reg_addr, `FCPL_HOST_PORT_LOCK_ADDR))
			reg_rdata <= {7'h00, lock_bit};
		else
			reg_rdata <= 8'h00;
	end
end

endmodule

// ===== testbench/fcpl_host.sv
/* Host model: register strobes and the select strobe pin.
   Assumes tasks are called one at a time, just after an mclk edge. */
`timescale 1ns/100ps
module fcpl_host
(
	input wire mclk,
	output logic [15:0] reg_addr = 16'h0000,
	output logic [7:0] reg_wdata = 8'h00,
	output logic reg_wr = 1'b0,
	output logic reg_rd = 1'b0,
	output logic select_strobe_pin = 1'b1
);
	// One access held to its taking edge, then a spare cycle for read data
	task automatic op(input [15:0] a, input [7:0] d, input w);
		{reg_addr, reg_wdata, reg_wr, reg_rd} = {a, d, w, !w};
		@(posedge mclk) #2;
		{reg_wdata, reg_wr, reg_rd} = {~d, 2'b00}; // Stale data must not linger
		@(posedge mclk) #2;
	endtask
	// Pin level changes, spaced wide of the synchroniser
	task automatic tg(input int n);
		repeat (n)
		begin
			select_strobe_pin = ~select_strobe_pin;
			repeat (4) @(posedge mclk);
			#2;
		end
	endtask
endmodule

// ===== testbench/fcpl_chk.sv
/* Checker of the config and lock bank.
   Assumes it is bound to fcpl_top and sees its ports only. */
`timescale 1ns/100ps
module fcpl_chk
(
	input wire mclk,
	input wire arst_n,
	input wire [15:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire spi_active,
	input wire port_locked,
	input wire [3:0] second_input_sel,
	input wire frontend_clock_output,
	input wire frontend_soft_reset
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	// Writes to each register
	wire cw = reg_wr && reg_addr == 16'he708;
	wire lw = reg_wr && reg_addr == 16'hea00;
	pulse_once_a: assert property (cw && reg_wdata[7] |=> frontend_soft_reset ##1
		!frontend_soft_reset) else $error("pulse");
	sel_copy_a: assert property (cw |-> ##2 second_input_sel == $past(reg_wdata[3:0], 2))
		else $error("sel");
	clk_hold_a: assert property (cw && reg_wdata[6] |=> ##1 frontend_clock_output)
		else $error("clk");
	lock_keep_a: assert property (port_locked |=> port_locked) else $error("lock");
	spi_keep_a: assert property (spi_active |=> spi_active) else $error("spi");
	strobe_ign_a: assert property (port_locked && !spi_active |=> !spi_active)
		else $error("ign");
	spi_lock_a: assert property (spi_active && lw |=> port_locked) else $error("slk");
	spi_rise_a: assert property ($rose(spi_active) |-> !$past(port_locked))
		else $error("up");
	cover property ($rose(spi_active));
	cover property ($rose(port_locked));
	cover property (frontend_soft_reset);
endmodule
bind fcpl_top fcpl_chk u_chk (.*);

// ===== testbench/fcpl_top_test.sv
/* Bench of the config and lock bank.
   Assumes fcpl_host drives bus and pin; the checker is bound in. */
`timescale 1ns/100ps
module fcpl_top_test;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	int n_errors = 0;
	int compares = 0;
	int cyc = 0;
	wire [15:0] reg_addr;
	wire [7:0] reg_wdata, reg_rdata;
	wire [3:0] second_input_sel;
	wire reg_wr, reg_rd, select_strobe_pin, spi_active, port_locked;
	wire frontend_clock_output, frontend_soft_reset;
	logic [7:0] d;
	logic [7:0] e = 8'h0f;
	int n_rst = 0;
	int x_rst = 0;
	// Soft reset pulses seen at the pin
	always @(posedge mclk)
		if (frontend_soft_reset === 1'b1)
			n_rst++;
	fcpl_host host (.*);
	fcpl_top #(.CLK_HALF(2)) DUT (.*);
	// ****
	// Clock, hang guard, helpers
	// ****
	always #10 mclk = ~mclk;
	always @(posedge mclk)
		if (++cyc == 1000)
		begin
			n_errors++;
			complete_run();
		end
	// Reserved and self-clearing bits read back as zero
	function automatic logic [7:0] rb(input logic [7:0] v);
		return v & 8'h4f;
	endfunction
	task automatic chk(input string s, input logic [7:0] x, g);
		compares++;
		if (g !== x)
		begin
			n_errors++;
			$display("BAD %s exp %h got %h", s, x, g);
		end
	endtask
	task automatic complete_run();
		$display("compares %0d errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Main sequence: defaults, config writes, I2C lock, SPI lock
	initial
	begin
		void'($urandom(96929));
		repeat (6) @(posedge mclk);
		#2 arst_n = 1'b1;
		for (int i = 0; i < 13; i++)
		begin
			host.op(16'he708, 8'h00, 0);
			chk("cfg", e, reg_rdata);
			chk("sel", {4'h0, e[3:0]}, {4'h0, second_input_sel});
			if (e[6])
				chk("clk", 8'h01, {7'h00, frontend_clock_output});
			else
			begin
				d[0] = frontend_clock_output;
				repeat (2) @(posedge mclk);
				#2;
				chk("run", {7'h00, ~d[0]}, {7'h00, frontend_clock_output});
			end
			d = i == 0 ? 8'hf0 : 8'($urandom);
			host.op(16'he708, d, 1);
			x_rst += d[7];
			e = rb(d);
		end
		host.op(16'he70a, 8'h00, 0);
		chk("hole", 8'h00, reg_rdata);
		chk("swrst", 8'(x_rst), 8'(n_rst));
		$display("config test done");
		host.op(16'hea00, 8'h01, 1);
		host.op(16'hea00, 8'h00, 1);
		host.tg(4);
		host.op(16'hea00, 8'h00, 0);
		chk("lock", 8'h01, reg_rdata);
		chk("spi", 8'h00, {7'h00, spi_active});
		$display("lock test done");
		arst_n = 1'b0;
		repeat (6) @(posedge mclk);
		#2 arst_n = 1'b1;
		host.tg(3);
		host.op(16'hea00, 8'h00, 1);
		host.tg(4);
		chk("spi", 8'h81, {spi_active, 6'h00, port_locked});
		$display("spi test done");
		complete_run();
	end
endmodule
